// >>> rtl/dgws_pkg.sv
package dgws_pkg;

	// ----------------------------------------------------------------
	// Widths and sizes
	// ----------------------------------------------------------------
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int SAMPLE_W = 12;
	localparam int INTERVAL_W = 24;
	localparam int ITER_W = 32;
	localparam int CHAN_W = 3;
	localparam int MAX_CHANS = 4;
	localparam int FIFO_DEPTH_DEF = 16;

	// ----------------------------------------------------------------
	// Interval limits and reset values
	// ----------------------------------------------------------------
	localparam logic [INTERVAL_W-1:0] INTERVAL_MIN_EXTERNAL = 24'h000008;
	localparam logic [INTERVAL_W-1:0] INTERVAL_MIN_INTERNAL = 24'h000028;
	localparam logic [INTERVAL_W-1:0] INTERVAL_MAX = 24'hFFFFFF;
	localparam logic [INTERVAL_W-1:0] PACE_RESET = 24'h000000;
	localparam logic [WORD_W-1:0] COUNT_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DAC_GROUP_FIRST,
		DAC_GROUP_SECOND,
		DAC_GROUP_BOTH
	} dgws_group_t;

	typedef enum logic [1:0] {
		STOP_SOURCE_SOFTWARE,
		STOP_SOURCE_AUX_ZERO,
		STOP_SOURCE_ANALOG_TRIGGER,
		STOP_SOURCE_AUX_ONE
	} dgws_stop_src_t;

	typedef enum logic [1:0] {
		STOP_AT_ONCE,
		STOP_AT_UPDATE_TERMINAL,
		STOP_AT_ITERATION_END
	} dgws_stop_mode_t;

	typedef enum {
		ST_IDLE,
		ST_WAIT,
		ST_EMIT
	} dgws_state_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		dgws_group_t group;
		dgws_stop_src_t [1:0] stop_source_select;
		dgws_stop_mode_t stop_mode;
		logic [INTERVAL_W-1:0] samples_per_channel_count;
		logic [ITER_W-1:0] iterations;
		logic [INTERVAL_W-1:0] channel_update_interval;
		logic internal_timebase;
		logic definite;
		logic double_buffered;
		logic fifo_preload;
		logic [1:0][CHAN_W-1:0] chan_num;
		logic [1:0][MAX_CHANS-1:0][CHAN_W-1:0] chan_order;
	} dgws_cfg_t;

	typedef struct packed {
		logic strobe;
		logic [CHAN_W-1:0] chan;
		logic [SAMPLE_W-1:0] code;
	} dgws_dac_t;

endpackage : dgws_pkg

// >>> rtl/dgws_top.sv
`timescale 1ns/1ps
module dgws_top #(
	parameter int FIFO_DEPTH = dgws_pkg::FIFO_DEPTH_DEF
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire dgws_pkg::dgws_cfg_t cfg,
	input wire logic start,
	input wire logic stop_soft,
	input wire logic aux_input_zero,
	input wire logic aux_input_one,
	input wire logic analog_trigger,
	input wire logic dma_valid,
	input wire logic [dgws_pkg::WORD_W-1:0] dma_data,
	output logic dma_ready,
	output dgws_pkg::dgws_dac_t [1:0] dac_out,
	output logic [1:0] running,
	output logic [1:0] stopped,
	output logic buffer_select,
	output logic [dgws_pkg::WORD_W-1:0] written_sample_count,
	output logic start_refused
);

	localparam int AW = $clog2(FIFO_DEPTH);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sync_a0, sync_a1, sync_at;
	logic [2:0] next_sync_a0, next_sync_a1, next_sync_at;
	logic ev_a0, ev_a1, ev_at;

	// Stage 0 only feeds stage 1; edges are taken from stages 1 and 2
	always_comb begin
		next_sync_a0 = {sync_a0[1:0], aux_input_zero};
		next_sync_a1 = {sync_a1[1:0], aux_input_one};
		next_sync_at = {sync_at[1:0], analog_trigger};
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sync_a0 <= 3'h0;
			sync_a1 <= 3'h0;
			sync_at <= 3'h0;
		end else begin
			sync_a0 <= next_sync_a0;
			sync_a1 <= next_sync_a1;
			sync_at <= next_sync_at;
		end
	end

	assign ev_a0 = sync_a0[1] & ~sync_a0[2];
	assign ev_a1 = sync_a1[1] & ~sync_a1[2];
	assign ev_at = sync_at[1] & ~sync_at[2];

	// Picks the stop request of one group from its chosen source
	function automatic logic stop_hit(input dgws_pkg::dgws_stop_src_t s, input logic sw, input logic a0,
		input logic at, input logic a1);
		case (s)
			dgws_pkg::STOP_SOURCE_SOFTWARE: stop_hit = sw;
			dgws_pkg::STOP_SOURCE_AUX_ZERO: stop_hit = a0;
			dgws_pkg::STOP_SOURCE_ANALOG_TRIGGER: stop_hit = at;
			default: stop_hit = a1;
		endcase
	endfunction : stop_hit

	// ----------------------------------------------------------------
	// Group FIFOs and DMA unpacking
	// ----------------------------------------------------------------
	logic [dgws_pkg::HALF_W-1:0] mem [2][FIFO_DEPTH];
	logic [AW-1:0] wr_ptr [2], rd_ptr [2], next_wr_ptr [2], next_rd_ptr [2];
	logic [AW:0] fill [2], next_fill [2], play [2], next_play [2];
	logic [1:0] act, push, pop, full;
	logic [dgws_pkg::HALF_W-1:0] half [2];

	assign act[0] = cfg.group != dgws_pkg::DAC_GROUP_SECOND;
	assign act[1] = cfg.group != dgws_pkg::DAC_GROUP_FIRST;
	assign full[0] = fill[0] == (AW+1)'(FIFO_DEPTH);
	assign full[1] = fill[1] == (AW+1)'(FIFO_DEPTH);
	assign half[0] = dma_data[15:0];
	assign half[1] = dma_data[31:16];
	// Preloaded playback must not be disturbed by DMA while running
	assign dma_ready = !(cfg.fifo_preload && |running) && !(act[0] && full[0]) && !(act[1] && full[1]);
	assign push = {2{dma_valid & dma_ready}} & act;

	// ----------------------------------------------------------------
	// Pacer and group sequencers
	// ----------------------------------------------------------------
	dgws_pkg::dgws_state_t state [2], next_state [2];
	logic [1:0] seq_idx [2], next_seq_idx [2];
	logic [dgws_pkg::INTERVAL_W-1:0] upd_cnt [2], next_upd_cnt [2];
	logic [dgws_pkg::ITER_W-1:0] iter_cnt [2], next_iter_cnt [2];
	logic [1:0] pend, next_pend, next_stopped, hit, emit, seq_end, pass_end, iter_done, halt;
	logic [dgws_pkg::INTERVAL_W-1:0] pace_cnt, next_pace_cnt;
	logic tick, refuse, accept, next_buffer_select, next_start_refused, lead;
	logic [AW:0] play_inc [2];
	logic [dgws_pkg::WORD_W-1:0] next_written;
	dgws_pkg::dgws_dac_t [1:0] next_dac;

	// Settings the device cannot run with are refused at start
	assign refuse = (cfg.double_buffered && cfg.fifo_preload)
		|| cfg.iterations == 32'h00000000
		|| cfg.channel_update_interval < (cfg.internal_timebase ? dgws_pkg::INTERVAL_MIN_INTERNAL
			: dgws_pkg::INTERVAL_MIN_EXTERNAL)
		|| (cfg.double_buffered && cfg.samples_per_channel_count[0]);
	assign accept = start && !(|running) && !refuse;
	// One pacer serves both groups so a combined run shares its rate
	assign tick = |running && pace_cnt == dgws_pkg::PACE_RESET;
	assign lead = act[0] ? 1'b0 : 1'b1;

	always_comb begin
		next_pace_cnt = (tick || !(|running)) ? cfg.channel_update_interval - 24'h000001 : pace_cnt - 24'h000001;
		next_written = accept ? dgws_pkg::COUNT_RESET : written_sample_count;
		next_buffer_select = accept ? 1'b0 : buffer_select;
		next_start_refused = start && !(|running) && refuse;
		next_stopped = stopped;
		next_pend = pend;
		next_dac = dac_out;
		hit = 2'b00;
		emit = 2'b00;
		seq_end = 2'b00;
		pass_end = 2'b00;
		iter_done = 2'b00;
		halt = 2'b00;
		pop = 2'b00;
		for (int g = 0; g < 2; g++) begin
			next_state[g] = state[g];
			next_seq_idx[g] = seq_idx[g];
			next_upd_cnt[g] = upd_cnt[g];
			next_iter_cnt[g] = iter_cnt[g];
			next_play[g] = play[g];
			play_inc[g] = play[g] + (AW+1)'(1);
			hit[g] = stop_hit(cfg.stop_source_select[g], stop_soft, ev_a0, ev_at, ev_a1);
			if (accept && act[g]) begin
				next_state[g] = dgws_pkg::ST_WAIT;
				next_seq_idx[g] = 2'h0;
				next_upd_cnt[g] = dgws_pkg::PACE_RESET;
				next_iter_cnt[g] = dgws_pkg::COUNT_RESET;
				next_play[g] = '0;
				next_pend[g] = 1'b0;
				next_stopped[g] = 1'b0;
			end else if (state[g] != dgws_pkg::ST_IDLE) begin
				emit[g] = state[g] == dgws_pkg::ST_EMIT && fill[g] != '0;
				seq_end[g] = emit[g] && {1'b0, seq_idx[g]} == cfg.chan_num[g] - 3'h1;
				// Preloaded data replays whole FIFO contents; the update count is unused
				pass_end[g] = seq_end[g] && (cfg.fifo_preload ? play_inc[g] == fill[g]
					: next_upd_cnt[g] + 24'h000001 == cfg.samples_per_channel_count);
				iter_done[g] = pass_end[g] && iter_cnt[g] + 32'h00000001 == cfg.iterations;
				if (state[g] == dgws_pkg::ST_WAIT && tick) begin
					next_state[g] = dgws_pkg::ST_EMIT;
					next_seq_idx[g] = 2'h0;
				end
				if (emit[g]) begin
					next_dac[g].strobe = 1'b1;
					next_dac[g].chan = cfg.chan_order[g][seq_idx[g]];
					next_dac[g].code = mem[g][rd_ptr[g] + play[g][AW-1:0]][dgws_pkg::SAMPLE_W-1:0];
					next_seq_idx[g] = seq_idx[g] + 2'h1;
					if (cfg.fifo_preload) begin
						next_play[g] = play_inc[g] == fill[g] ? '0 : play_inc[g];
					end else begin
						pop[g] = 1'b1;
					end
				end
				if (seq_end[g]) begin
					next_state[g] = dgws_pkg::ST_WAIT;
					next_upd_cnt[g] = pass_end[g] ? dgws_pkg::PACE_RESET : upd_cnt[g] + 24'h000001;
				end
				if (pass_end[g]) begin
					next_iter_cnt[g] = iter_done[g] ? dgws_pkg::COUNT_RESET : iter_cnt[g] + 32'h00000001;
				end
				// A deferred stop is remembered until its boundary arrives
				if (hit[g] && cfg.stop_mode != dgws_pkg::STOP_AT_ONCE) begin
					next_pend[g] = 1'b1;
				end
				halt[g] = (hit[g] && cfg.stop_mode == dgws_pkg::STOP_AT_ONCE)
					|| (iter_done[g] && cfg.definite && !cfg.double_buffered)
					|| ((pend[g] || hit[g]) && cfg.stop_mode == dgws_pkg::STOP_AT_UPDATE_TERMINAL
						&& pass_end[g])
					|| ((pend[g] || hit[g]) && cfg.stop_mode == dgws_pkg::STOP_AT_ITERATION_END
						&& iter_done[g]);
				if (halt[g]) begin
					next_state[g] = dgws_pkg::ST_IDLE;
					next_pend[g] = 1'b0;
					next_stopped[g] = 1'b1;
				end
			end
			if (!emit[g]) begin
				next_dac[g].strobe = 1'b0;
			end
			next_wr_ptr[g] = wr_ptr[g] + AW'(push[g]);
			next_rd_ptr[g] = rd_ptr[g] + AW'(pop[g]);
			next_fill[g] = fill[g] + (AW+1)'(push[g]) - (AW+1)'(pop[g]);
		end
		next_written = next_written + 32'(emit[0]) + 32'(emit[1]);
		// The host's two buffers alternate at each pass end of the lead group
		if (cfg.double_buffered && pass_end[lead]) begin
			next_buffer_select = ~buffer_select;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pace_cnt <= dgws_pkg::PACE_RESET;
			written_sample_count <= dgws_pkg::COUNT_RESET;
			buffer_select <= 1'b0;
			start_refused <= 1'b0;
			stopped <= 2'b00;
			pend <= 2'b00;
			dac_out <= '0;
			for (int g = 0; g < 2; g++) begin
				state[g] <= dgws_pkg::ST_IDLE;
				seq_idx[g] <= 2'h0;
				upd_cnt[g] <= dgws_pkg::PACE_RESET;
				iter_cnt[g] <= dgws_pkg::COUNT_RESET;
				play[g] <= '0;
				wr_ptr[g] <= '0;
				rd_ptr[g] <= '0;
				fill[g] <= '0;
			end
		end else begin
			pace_cnt <= next_pace_cnt;
			written_sample_count <= next_written;
			buffer_select <= next_buffer_select;
			start_refused <= next_start_refused;
			stopped <= next_stopped;
			pend <= next_pend;
			dac_out <= next_dac;
			for (int g = 0; g < 2; g++) begin
				state[g] <= next_state[g];
				seq_idx[g] <= next_seq_idx[g];
				upd_cnt[g] <= next_upd_cnt[g];
				iter_cnt[g] <= next_iter_cnt[g];
				play[g] <= next_play[g];
				wr_ptr[g] <= next_wr_ptr[g];
				rd_ptr[g] <= next_rd_ptr[g];
				fill[g] <= next_fill[g];
			end
		end
	end

	// Sample storage carries no reset; only pointers define its contents
	always_ff @(posedge sys_clk) begin
		for (int g = 0; g < 2; g++) begin
			if (push[g]) begin
				mem[g][wr_ptr[g]] <= half[g];
			end
		end
	end

	assign running[0] = state[0] != dgws_pkg::ST_IDLE;
	assign running[1] = state[1] != dgws_pkg::ST_IDLE;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_quiet;
		!tick [*7];
	endsequence

	sequence s_stop_once(int g);
		running[g] && hit[g] && cfg.stop_mode == dgws_pkg::STOP_AT_ONCE;
	endsequence

	AST_STOP_AT_ONCE: assert property (s_stop_once(0) |=> !running[0] && stopped[0])
		else $error("first group kept running after an immediate stop");
	AST_UC_NO_EARLY: assert property (running[0] && hit[0]
		&& cfg.stop_mode == dgws_pkg::STOP_AT_UPDATE_TERMINAL && !pass_end[0] |=> running[0] && pend[0])
		else $error("update-terminal stop ended the group early");
	AST_IC_NO_EARLY: assert property (running[0] && hit[0]
		&& cfg.stop_mode == dgws_pkg::STOP_AT_ITERATION_END && !iter_done[0] |=> running[0])
		else $error("iteration-end stop ended the group early");
	AST_SRC_SELECT: assert property (running[0] && stop_soft && !ev_a0 && !ev_at && !ev_a1
		&& cfg.stop_source_select[0] != dgws_pkg::STOP_SOURCE_SOFTWARE |-> !hit[0])
		else $error("software stop acted on a group wired to a pin source");
	AST_SPLIT_LOW: assert property (push[0] |=> mem[0][$past(wr_ptr[0])] == $past(dma_data[15:0]))
		else $error("lower word half did not reach the first FIFO");
	AST_SPLIT_HIGH: assert property (push[1] |=> mem[1][$past(wr_ptr[1])] == $past(dma_data[31:16]))
		else $error("upper word half did not reach the second FIFO");
	AST_ORDER: assert property (emit[0] && seq_idx[0] == 2'h0 |=> dac_out[0].strobe
		&& dac_out[0].chan == $past(cfg.chan_order[0][0]))
		else $error("first sample of a sequence went to the wrong channel");
	AST_PACE: assert property (tick && cfg.channel_update_interval >= dgws_pkg::INTERVAL_MIN_EXTERNAL
		&& $stable(cfg.channel_update_interval) |=> pace_cnt == $past(cfg.channel_update_interval) - 24'h000001
		##0 s_quiet)
		else $error("pacer did not reload the update interval");
	AST_REFUSE_MIX: assert property (start && !(|running) && cfg.double_buffered && cfg.fifo_preload
		|=> start_refused && !(|running))
		else $error("double buffering started together with FIFO preload");
	AST_STOP_BITS: assert property ($fell(running[1]) |-> stopped[1] ##1 stopped[1] || running[1])
		else $error("second group stop bit not set when it halted");
	AST_COUNT_HOLD: assert property (!(|running) && !start |=> $stable(written_sample_count))
		else $error("written sample count moved while idle");
	AST_INDEFINITE: assert property (running[0] && !cfg.definite && !hit[0] && !pend[0]
		&& cfg.stop_mode == dgws_pkg::STOP_AT_ONCE |=> running[0])
		else $error("indefinite run ended without a stop request");

endmodule : dgws_top

// >>> sim/dac_group_waveform_sequencer_tb.sv
`timescale 1ns/1ps
module dac_group_waveform_sequencer_tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	dgws_pkg::dgws_cfg_t cfg = '0;
	logic start = 1'b0;
	logic [3:0] pins = 4'h0;
	logic stall_en = 1'b0;
	logic refused_seen = 1'b0;
	logic dma_valid, dma_ready, buffer_select, start_refused;
	logic [31:0] dma_data, written_sample_count;
	dgws_pkg::dgws_dac_t [1:0] dac_out;
	logic [1:0] running, stopped;
	logic [14:0] seen_q[2][$];
	logic [14:0] exp_q[2][$];
	int t_q[$];
	int sidx[2];
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	int nch = 1;
	int rot, lead;

	dgws_top #(.FIFO_DEPTH(4)) dut_u (.sys_clk(sys_clk), .reset(reset), .cfg(cfg), .start(start),
		.stop_soft(pins[0]), .aux_input_zero(pins[1]), .analog_trigger(pins[2]), .aux_input_one(pins[3]),
		.dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready), .dac_out(dac_out),
		.running(running), .stopped(stopped), .buffer_select(buffer_select),
		.written_sample_count(written_sample_count), .start_refused(start_refused));
	dgws_host_model host_u (.sys_clk(sys_clk), .reset(reset), .dma_ready(dma_ready), .stall_en(stall_en),
		.dma_valid(dma_valid), .dma_data(dma_data));

	// Free-running clock
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// Monitor and watchdog
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			report_and_stop();
		end
		if (start_refused === 1'b1) refused_seen = 1'b1;
		for (int g = 0; g < 2; g++) begin
			if (dac_out[g].strobe === 1'b1) begin
				if (g == lead && seen_q[g].size() % nch == 0) t_q.push_back(cyc);
				seen_q[g].push_back({dac_out[g].chan, dac_out[g].code});
			end
		end
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// Reset also empties the FIFOs, so each scenario starts clean
	task automatic do_reset();
		@(negedge sys_clk);
		reset = 1'b1;
		repeat (5) @(negedge sys_clk);
		reset = 1'b0;
		for (int g = 0; g < 2; g++) begin
			seen_q[g].delete();
			exp_q[g].delete();
		end
		t_q.delete();
		stall_en = 1'b0;
		@(negedge sys_clk);
	endtask : do_reset
	// Legal default setup with a random channel count and rotation
	task automatic base(input int grp);
		cfg = '0;
		cfg.group = dgws_pkg::dgws_group_t'(grp);
		cfg.samples_per_channel_count = 24'h2;
		cfg.iterations = 32'h2;
		cfg.channel_update_interval = 24'h8;
		cfg.definite = 1'b1;
		nch = $urandom_range(4, 1);
		rot = $urandom_range(3);
		lead = (grp == 1) ? 1 : 0;
		for (int g = 0; g < 2; g++) begin
			cfg.chan_num[g] = 3'(nch);
			sidx[g] = 0;
			for (int i = 0; i < 4; i++) cfg.chan_order[g][i] = 3'(g * 4 + (i + rot) % 4);
		end
	endtask : base
	// Random words; expected channel follows the configured order
	task automatic feed(input int n);
		logic [31:0] w;
		for (int k = 0; k < n; k++) begin
			w = $urandom() & 32'h0FFF0FFF;
			host_u.push(w);
			for (int g = 0; g < 2; g++) begin
				if (cfg.group == dgws_pkg::DAC_GROUP_BOTH || int'(cfg.group) == g) begin
					exp_q[g].push_back({cfg.chan_order[g][sidx[g] % nch], w[g*16 +: 12]});
					sidx[g]++;
				end
			end
		end
	endtask : feed
	task automatic go();
		@(negedge sys_clk);
		refused_seen = 1'b0;
		start = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask : go
	// Software stop is one cycle; pins stay up long enough for the synchroniser
	task automatic stop_req(input int src);
		@(negedge sys_clk);
		pins[src] = 1'b1;
		repeat (src == 0 ? 1 : 3) @(negedge sys_clk);
		pins[src] = 1'b0;
	endtask : stop_req
	task automatic wait_halt();
		for (int k = 0; k < 4000 && running !== 2'b00; k++) @(negedge sys_clk);
		check("halted", running, 0);
		// The strobe launched with the halt reaches the monitor one edge later
		repeat (2) @(negedge sys_clk);
	endtask : wait_halt
	task automatic wait_seen(input int n);
		for (int k = 0; k < 4000 && seen_q[0].size() < n; k++) @(negedge sys_clk);
		check("seen", seen_q[0].size() >= n, 1);
	endtask : wait_seen
	task automatic compare();
		for (int g = 0; g < 2; g++) begin
			check("samples", seen_q[g].size(), exp_q[g].size());
			for (int i = 0; i < seen_q[g].size() && i < exp_q[g].size(); i++) begin
				check("sample", seen_q[g][i], exp_q[g][i]);
			end
		end
	endtask : compare
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h2406));
		do_reset();
		check("ready", dma_ready, 1);
		check("running", running, 0);
		check("stopped", stopped, 0);
		check("count", written_sample_count, 0);
		// Each invalid setup is turned away
		for (int i = 0; i < 5; i++) begin
			base(0);
			case (i)
				0: cfg.iterations = 32'h0;
				1: cfg.channel_update_interval = 24'h7;
				2: begin
					cfg.internal_timebase = 1'b1;
					cfg.channel_update_interval = 24'h27;
				end
				3: cfg.samples_per_channel_count = 24'h3;
				default: cfg.fifo_preload = 1'b1;
			endcase
			if (i >= 3) cfg.double_buffered = 1'b1;
			go();
			check("refused", refused_seen, 1);
			check("running", running, 0);
		end
		// Definite runs on each group at the lowest legal interval
		for (int grp = 0; grp < 3; grp++) begin
			do_reset();
			base(grp);
			if (grp == 2) begin
				cfg.internal_timebase = 1'b1;
				cfg.channel_update_interval = 24'h28;
			end
			feed(4 * nch);
			go();
			wait_halt();
			compare();
			check("stopped", stopped, grp == 2 ? 3 : grp + 1);
			check("count", written_sample_count, (grp == 2 ? 8 : 4) * nch);
			check("buffer", buffer_select, 0);
			for (int i = 1; i < t_q.size(); i++) begin
				check("period", t_q[i] - t_q[i - 1], cfg.channel_update_interval);
			end
		end
		// Immediate stop from every source, with the FIFO starved after one sample; a request from the next source is ignored
		for (int src = 0; src < 4; src++) begin
			do_reset();
			base(0);
			cfg.definite = 1'b0;
			cfg.stop_source_select[0] = dgws_pkg::dgws_stop_src_t'(src);
			feed(1);
			go();
			repeat (30) @(negedge sys_clk);
			stop_req((src + 1) % 4);
			repeat (4) @(negedge sys_clk);
			check("running", running, 1);
			stop_req(src);
			repeat (4) @(negedge sys_clk);
			check("running", running, 0);
			check("count", written_sample_count, 1);
		end
		// Deferred stops finish the pass or the iteration, host stalling
		for (int m = 1; m < 3; m++) begin
			do_reset();
			base(0);
			cfg.definite = 1'b0;
			cfg.stop_mode = dgws_pkg::dgws_stop_mode_t'(m);
			stall_en = 1'b1;
			feed(16 * nch);
			go();
			wait_seen(1);
			stop_req(0);
			check("running", running, 1);
			wait_halt();
			check("count", written_sample_count, 2 * m * nch);
			exp_q[0] = exp_q[0][0:2*m*nch-1];
			compare();
		end
		// Preloaded playback replays the FIFO and takes no DMA
		do_reset();
		base(0);
		cfg.fifo_preload = 1'b1;
		cfg.samples_per_channel_count = 24'h7;
		feed(nch);
		repeat (20) @(negedge sys_clk);
		go();
		check("ready", dma_ready, 0);
		for (int i = 0; i < nch; i++) exp_q[0].push_back(exp_q[0][i]);
		wait_halt();
		compare();
		check("count", written_sample_count, 2 * nch);
		// Double buffering alternates buffers and ignores the definite flag
		do_reset();
		base(0);
		cfg.double_buffered = 1'b1;
		cfg.iterations = 32'h1;
		feed(6 * nch);
		go();
		wait_seen(6 * nch);
		repeat (20) @(negedge sys_clk);
		check("running", running, 1);
		check("buffer", buffer_select, 1);
		stop_req(0);
		wait_halt();
		compare();
		report_and_stop();
	end
endmodule : dac_group_waveform_sequencer_tb

// >>> sim/dgws_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host DMA source
// ----------------------------------------------------------------
module dgws_host_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic dma_ready,
	input wire logic stall_en,
	output logic dma_valid = 1'b0,
	output logic [31:0] dma_data = 32'h0
);
	logic [31:0] q[$];
	logic taken = 1'b0;
	// Caller packs one half per group, codes kept to 12 bits
	task automatic push(input logic [31:0] w);
		q.push_back(w);
	endtask : push
	// Acceptance is judged only at the sampling edge
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			taken = 1'b0;
		end else begin
			taken = dma_valid & dma_ready;
		end
	end
	// Offer moves at the falling edge; idle data toggles so nothing stale looks valid
	always @(negedge sys_clk or posedge reset) begin
		if (reset) begin
			q.delete();
			dma_valid = 1'b0;
		end else begin
			if (taken) begin
				void'(q.pop_front());
			end
			// Each signal is written once per edge; an offer not yet taken stays put
			if (taken || !dma_valid) begin
				if (q.size() != 0 && !(stall_en && $urandom_range(1) == 1)) begin
					dma_valid = 1'b1;
					dma_data = q[0];
				end else begin
					dma_valid = 1'b0;
					dma_data = ~dma_data;
				end
			end
		end
	end
endmodule : dgws_host_model
